// ---- cpsc_pkg.sv ----
// Package for the card power switch control block.
// Assumes APB byte addressing; each register sits in one aligned word.
package cpsc_pkg;
   // Address width and register indices; byte address is four times the index.
   localparam int unsigned ADDR_W   = 14;
   localparam int unsigned IDX_W    = 12;
   localparam logic [11:0] IDX_FIX_A = 12'h80E;
   localparam logic [11:0] IDX_FIX_B = 12'h80F;
   localparam logic [11:0] IDX_VAR   = 12'h811;
   localparam logic [11:0] IDX_IO    = 12'h812;
   localparam logic [11:0] IDX_PULL  = 12'h813;
   localparam logic [11:0] IDX_SENSE = 12'h814;
   localparam logic [11:0] IDX_ARM   = 12'h815;
   // Field positions of the control registers.
   localparam int unsigned FSEL_BIT = 5;
   localparam int unsigned EN_BIT   = 4;
   localparam int unsigned MODE_MSB = 3;
   localparam int unsigned VSEL_BIT = 6;
   localparam int unsigned TUNE_BIT = 5;
   localparam int unsigned HI_LSB   = 4;
   // Reset values.
   localparam logic [7:0] FIX_RST  = 8'h20;
   localparam logic [7:0] VAR_RST  = 8'h00;
   localparam logic [3:0] MODE_RST = 4'h0;
   // Number of channels: two fixed switches and one regulator.
   localparam int unsigned NCH = 3;
   localparam int unsigned VCH = 2;
endpackage

// ---- cpsc_ctl.sv ----
// Card power switch control: two fixed switch channels and one regulator
// channel, each sharing a pad with an I/O that doubles as a supply sense input.
// Assumes a single 40 MHz clock, an APB master and asynchronous sense pins.
//
// Contract
// - Fixed switch registers reset to 0x20.
// - Card-power mode forces the pin input-only.
// - Pin input follows switch on or off.
// - No pull unless firmware enables one.
// - Bit 5 picks I/O or card-power function.
// - Bit 4 switches supply; forced zero in I/O.
// - Bits 3:0 current setting, default 200 mA.
// - Three registers map to sense pins 8-10.
// - Falling sense pin raises the short flag.
// - Regulator register resets to 0x00.
// - Regulator pin input follows regulator on.
// - Bit 6 selects 3.0V or 1.8V.
// - Regulator on disables the pin output.
// - Third pin senses the adjustable supply.
`timescale 1ns/1ps
`default_nettype none
module cpsc_ctl
   import cpsc_pkg::*;
(
   // Clock and reset.
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   // APB slave.
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Shared pads, index 0..2 for I/O 8, 9 and 10.
   input  wire logic [NCH-1:0]    sense_pin_i,
   output logic      [NCH-1:0]    pin_out_o,
   output logic      [NCH-1:0]    pin_out_en_n_o,
   output logic      [NCH-1:0]    pin_in_en_o,
   output logic      [NCH-1:0]    pull_up_o,
   output logic      [NCH-1:0]    pull_down_o,
   // Supply controls.
   output logic      [NCH-1:0]    supply_switch_on_o,
   output logic      [NCH-2:0]    card_supply_mode_o,
   output logic      [3:0]        current_setting_a_o,
   output logic      [3:0]        current_setting_b_o,
   output logic                   volt_1v8_o,
   output logic                   pad_tune_o,
   output logic      [NCH-1:0]    short_flag_o
);

   // Next fixed register fields {select, enable, setting}; enable only sticks
   // in card-power mode, so clearing the select also drops the supply.
   function automatic logic [5:0] fix_wr(input logic [7:0] d);
      fix_wr = {d[FSEL_BIT], d[FSEL_BIT] & d[EN_BIT], d[MODE_MSB:0]};
   endfunction

   // Read view of a fixed switch register; bits 7:6 read as zero.
   function automatic logic [7:0] fix_rd(input logic [5:0] f);
      fix_rd = {2'h0, f};
   endfunction

   // Register state.
   logic [5:0]     fix_a_r, fix_a_nxt;
   logic [5:0]     fix_b_r, fix_b_nxt;
   logic           vsel_r, vsel_nxt;
   logic           tune_r, tune_nxt;
   logic           ven_r, ven_nxt;
   logic [NCH-1:0] io_oe_r, io_oe_nxt;
   logic [NCH-1:0] io_val_r, io_val_nxt;
   logic [NCH-1:0] pu_r, pu_nxt;
   logic [NCH-1:0] pd_r, pd_nxt;
   logic [NCH-1:0] arm_r, arm_nxt;
   logic [NCH-1:0] flag_r, flag_nxt;
   logic [31:0]    rdata_r, rdata_nxt;
   logic           ready_r, ready_nxt;
   logic           err_r, err_nxt;

   // Sense pin synchroniser and the settled level.
   logic [NCH-1:0] s1_r, s2_r, s3_r;
   logic [NCH-1:0] lvl_r, lvl_nxt;
   logic [NCH-1:0] fall;

   // Pad outputs, registered so every port comes from a flip-flop.
   logic [NCH-1:0] pout_r, pout_nxt;
   logic [NCH-1:0] poen_n_r, poen_n_nxt;
   logic [NCH-1:0] pin_r, pin_nxt;
   logic [NCH-1:0] pup_r, pup_nxt;
   logic [NCH-1:0] pdn_r, pdn_nxt;

   logic [IDX_W-1:0] idx;
   logic             setup;
   logic             wr;
   logic [NCH-1:0]   mode;
   logic [NCH-1:0]   on;

   assign idx   = paddr_i[ADDR_W-1:2];
   assign setup = psel_i & ~penable_i;
   assign wr    = psel_i & penable_i & ready_r & pwrite_i;
   assign mode  = {1'b1, fix_b_r[5], fix_a_r[5]};
   assign on    = {ven_r, fix_b_r[4], fix_a_r[4]};

   // Register writes land at the access edge on which pready is seen high.
   always_comb
   begin
      fix_a_nxt  = fix_a_r;
      fix_b_nxt  = fix_b_r;
      vsel_nxt   = vsel_r;
      tune_nxt   = tune_r;
      ven_nxt    = ven_r;
      io_oe_nxt  = io_oe_r;
      io_val_nxt = io_val_r;
      pu_nxt     = pu_r;
      pd_nxt     = pd_r;
      arm_nxt    = arm_r;
      flag_nxt   = flag_r;
      if (wr)
      begin
         unique case (idx)
            IDX_FIX_A: fix_a_nxt = fix_wr(pwdata_i[7:0]);
            IDX_FIX_B: fix_b_nxt = fix_wr(pwdata_i[7:0]);
            IDX_VAR:
            begin
               vsel_nxt = pwdata_i[VSEL_BIT];
               tune_nxt = pwdata_i[TUNE_BIT];
               ven_nxt  = pwdata_i[EN_BIT];
            end
            IDX_IO:
            begin
               io_oe_nxt  = pwdata_i[NCH-1:0];
               io_val_nxt = pwdata_i[HI_LSB+NCH-1:HI_LSB];
            end
            IDX_PULL:
            begin
               pu_nxt = pwdata_i[NCH-1:0];
               pd_nxt = pwdata_i[HI_LSB+NCH-1:HI_LSB];
            end
            IDX_SENSE: flag_nxt = flag_r & ~pwdata_i[HI_LSB+NCH-1:HI_LSB];
            IDX_ARM:   arm_nxt  = pwdata_i[NCH-1:0];
            default:   flag_nxt = flag_r;
         endcase
      end
      // A falling edge in the clearing cycle still sets its flag.
      flag_nxt = flag_nxt | (fall & arm_r);
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fix_a_r  <= FIX_RST[5:0];
         fix_b_r  <= FIX_RST[5:0];
         vsel_r   <= VAR_RST[VSEL_BIT];
         tune_r   <= VAR_RST[TUNE_BIT];
         ven_r    <= VAR_RST[EN_BIT];
         io_oe_r  <= '0;
         io_val_r <= '0;
         pu_r     <= '0;
         pd_r     <= '0;
         arm_r    <= '0;
         flag_r   <= '0;
      end
      else
      begin
         fix_a_r  <= fix_a_nxt;
         fix_b_r  <= fix_b_nxt;
         vsel_r   <= vsel_nxt;
         tune_r   <= tune_nxt;
         ven_r    <= ven_nxt;
         io_oe_r  <= io_oe_nxt;
         io_val_r <= io_val_nxt;
         pu_r     <= pu_nxt;
         pd_r     <= pd_nxt;
         arm_r    <= arm_nxt;
         flag_r   <= flag_nxt;
      end
   end

   // Read data and the answer are prepared in the setup cycle, so pready is
   // high in the first access cycle; the slave never inserts wait states.
   always_comb
   begin
      rdata_nxt = '0;
      err_nxt   = 1'b0;
      ready_nxt = setup;
      if (setup)
      begin
         unique case (idx)
            IDX_FIX_A: rdata_nxt[7:0] = fix_rd(fix_a_r);
            IDX_FIX_B: rdata_nxt[7:0] = fix_rd(fix_b_r);
            IDX_VAR:
            begin
               rdata_nxt[VSEL_BIT] = vsel_r;
               rdata_nxt[TUNE_BIT] = tune_r;
               rdata_nxt[EN_BIT]   = ven_r;
            end
            IDX_IO:    rdata_nxt[7:0] = {1'b0, io_val_r, 1'b0, io_oe_r};
            IDX_PULL:  rdata_nxt[7:0] = {1'b0, pd_r, 1'b0, pu_r};
            IDX_SENSE: rdata_nxt[7:0] = {1'b0, flag_r, 1'b0, lvl_r};
            IDX_ARM:   rdata_nxt[NCH-1:0] = arm_r;
            default:   err_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_r <= '0;
         ready_r <= 1'b0;
         err_r   <= 1'b0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         err_r   <= err_nxt;
      end
   end

   // Sense pins pass three flops; a level counts once stages two and three
   // agree, which also rejects a single-cycle glitch.
   always_comb
   begin
      lvl_nxt = lvl_r;
      fall    = '0;
      for (int i = 0; i < NCH; i++)
      begin
         if (s2_r[i] == s3_r[i])
         begin
            lvl_nxt[i] = s3_r[i];
            fall[i]    = lvl_r[i] & ~s3_r[i] & pin_r[i];
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         lvl_r <= '0;
      end
      else
      begin
         s1_r  <= sense_pin_i;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   // Pad control: card-power mode makes the pin an input only, opened while
   // the supply is on; I/O mode hands the pad to firmware.
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         pout_nxt[i]   = io_val_r[i];
         poen_n_nxt[i] = ~(io_oe_r[i] & ~mode[i]);
         pin_nxt[i]    = mode[i] ? on[i] : 1'b1;
         pup_nxt[i]    = pu_r[i];
         pdn_nxt[i]    = pd_r[i];
      end
      // The regulator pin may drive only while the regulator is off.
      poen_n_nxt[VCH] = ~(io_oe_r[VCH] & ~ven_r);
      pin_nxt[VCH]    = ven_r;
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pout_r   <= '0;
         poen_n_r <= '1;
         pin_r    <= '0;
         pup_r    <= '0;
         pdn_r    <= '0;
      end
      else
      begin
         pout_r   <= pout_nxt;
         poen_n_r <= poen_n_nxt;
         pin_r    <= pin_nxt;
         pup_r    <= pup_nxt;
         pdn_r    <= pdn_nxt;
      end
   end

   // Outputs straight from flip-flops.
   assign prdata_o            = rdata_r;
   assign pready_o            = ready_r;
   assign pslverr_o           = err_r;
   assign pin_out_o           = pout_r;
   assign pin_out_en_n_o      = poen_n_r;
   assign pin_in_en_o         = pin_r;
   assign pull_up_o           = pup_r;
   assign pull_down_o         = pdn_r;
   assign supply_switch_on_o  = {ven_r, fix_b_r[EN_BIT], fix_a_r[EN_BIT]};
   assign card_supply_mode_o  = {fix_b_r[FSEL_BIT], fix_a_r[FSEL_BIT]};
   assign current_setting_a_o = fix_a_r[MODE_MSB:0];
   assign current_setting_b_o = fix_b_r[MODE_MSB:0];
   assign volt_1v8_o          = vsel_r;
   assign pad_tune_o          = tune_r;
   assign short_flag_o        = flag_r;

endmodule
`default_nettype wire

// ---- cpsc_ctl_sva.sv ----
// Checker for the card power switch control block.
// Sees only the top module ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module cpsc_ctl_chk
   import cpsc_pkg::*;
(
   // Watched ports.
   input wire logic              clock_i,
   input wire logic              rst_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pready_o,
   input wire logic [31:0]       prdata_o,
   input wire logic [NCH-1:0]    sense_pin_i,
   input wire logic [NCH-1:0]    pin_out_en_n_o,
   input wire logic [NCH-1:0]    pin_in_en_o,
   input wire logic [NCH-1:0]    supply_switch_on_o,
   input wire logic [NCH-2:0]    card_supply_mode_o,
   input wire logic [NCH-1:0]    short_flag_o
);
   // One domain, so clock and reset are given once.
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_answer;
      pready_o ##1 !pready_o;
   endsequence
   AST_APB_ANSWER: assert property (s_setup |=> s_answer)
      else $error("Setup not answered in one cycle.");
   AST_RSVD_HI: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
      else $error("Upper read bits not zero.");
   AST_IO_FORCED_A: assert property (!card_supply_mode_o[0] |-> !supply_switch_on_o[0])
      else $error("Switch a on in I/O mode.");
   AST_IO_FORCED_B: assert property (!card_supply_mode_o[1] |-> !supply_switch_on_o[1])
      else $error("Switch b on in I/O mode.");
   AST_OUT_OFF_A: assert property
      (card_supply_mode_o[0] && $past(card_supply_mode_o[0]) |-> pin_out_en_n_o[0])
      else $error("Pad a driven in card mode.");
   AST_IN_FOLLOW_A: assert property (card_supply_mode_o[0] && $stable(card_supply_mode_o[0])
      && $stable(supply_switch_on_o[0]) |-> pin_in_en_o[0] == supply_switch_on_o[0])
      else $error("Pad a input enable wrong.");
   AST_REG_OUT: assert property
      (supply_switch_on_o[2] && $past(supply_switch_on_o[2]) |-> pin_out_en_n_o[2])
      else $error("Regulator pad driven while on.");
   AST_REG_IN: assert property
      ($stable(supply_switch_on_o[2]) |-> pin_in_en_o[2] == supply_switch_on_o[2])
      else $error("Regulator pad input enable wrong.");
   AST_SHORT_CAUSE: assert property ($rose(short_flag_o[0]) |-> !$past(sense_pin_i[0], 3))
      else $error("Short flag without a fall.");
endmodule
bind cpsc_ctl cpsc_ctl_chk chk_u (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pready_o(pready_o), .prdata_o(prdata_o),
   .sense_pin_i(sense_pin_i), .pin_out_en_n_o(pin_out_en_n_o), .pin_in_en_o(pin_in_en_o),
   .supply_switch_on_o(supply_switch_on_o), .card_supply_mode_o(card_supply_mode_o),
   .short_flag_o(short_flag_o));
`default_nettype wire

// ---- cpsc_card_model.sv ----
// Card supplies seen from the sense pins.
// A supply reaches its level PON cycles after switch-on; a short grounds it.
`timescale 1ns/1ps
`default_nettype none
module cpsc_card_model #(parameter int PON = 4)
(
   // Switch state in, short command from the bench, sense level out.
   input  wire logic       clock_i,
   input  wire logic [2:0] sw_on_i,
   input  wire logic [2:0] short_i,
   output logic      [2:0] sense_o
);
   int cnt [3];
   // Ramp counters; an off supply is at ground, not at its last level.
   always_ff @(posedge clock_i)
      for (int i = 0; i < 3; i++)
         cnt[i] <= !sw_on_i[i] ? 0 : (cnt[i] < PON ? cnt[i] + 1 : PON);
   always_comb
      for (int i = 0; i < 3; i++)
         sense_o[i] = (cnt[i] == PON) && !short_i[i];
endmodule
`default_nettype wire

// ---- card_power_switch_control_test.sv ----
// Self-checking bench for the card power switch control block.
// Drives APB as master; the card model answers on the sense pins.
`timescale 1ns/1ps
`default_nettype none
module card_power_switch_control_test;
   import cpsc_pkg::*;
   logic              clock_i, rst_i, psel, pen, pwr, se, v18, tune, pready, pslverr;
   logic [ADDR_W-1:0] pa;
   logic [31:0]       pwd, rd, prdata;
   logic [2:0]        shrt, sns, oen, ien, sw, flg, pu, pd, pout;
   logic [1:0]        mode;
   logic [3:0]        cura, curb;
   int                err_total, n_tests;
   cpsc_ctl dut_u (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sense_pin_i(sns), .pin_out_o(pout), .pin_out_en_n_o(oen),
      .pin_in_en_o(ien), .pull_up_o(pu), .pull_down_o(pd), .supply_switch_on_o(sw),
      .card_supply_mode_o(mode), .current_setting_a_o(cura), .current_setting_b_o(curb),
      .volt_1v8_o(v18), .pad_tune_o(tune), .short_flag_o(flg));
   cpsc_card_model card_u (.clock_i(clock_i), .sw_on_i(sw), .short_i(shrt), .sense_o(sns));
   // Free-running 40 MHz clock.
   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         err_total++;
      end
   endtask
   // One APB transfer; waits for pready under a bound.
   task automatic apb(input logic w, input logic [11:0] ix, input logic [7:0] d);
      int k;
      @(posedge clock_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= {ix, 2'b00};
      pwd <= {24'h0, d};
      @(posedge clock_i);
      pen <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clock_i);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (k >= 20)
      begin
         chk(32'h0, 32'h1);
         test_done();
      end
   endtask
   task automatic rc(input logic [11:0] ix, input logic [7:0] e);
      apb(1'b0, ix, 8'h00);
      chk(rd, {24'h0, e});
   endtask
   task automatic t_reset();
      rc(IDX_FIX_A, 8'h20);
      rc(IDX_FIX_B, 8'h20);
      rc(IDX_VAR, 8'h00);
      chk(32'({pu, pd, ien}), 32'h0);
      chk(32'({cura, curb, mode}), 32'h3);
   endtask
   task automatic t_fixed();
      apb(1'b1, IDX_FIX_A, 8'h30);
      repeat (12) @(posedge clock_i);
      rc(IDX_SENSE, 8'h01);
      chk(32'({oen[0], ien[0], sw}), 32'h19);
      apb(1'b1, IDX_FIX_B, 8'hFF);
      rc(IDX_FIX_B, 8'h3F);
      chk(32'(curb), 32'hF);
      apb(1'b1, IDX_FIX_B, 8'h10);
      rc(IDX_FIX_B, 8'h00);
      chk(32'({mode, sw}), 32'h09);
      // In I/O mode firmware owns the pad; the pad flops lag by one cycle.
      apb(1'b1, IDX_IO, 8'h22);
      apb(1'b1, IDX_PULL, 8'h02);
      repeat (2) @(posedge clock_i);
      chk(32'({pout, oen, ien[1]}), 32'h2B);
      chk(32'({pu, pd}), 32'h10);
      apb(1'b1, IDX_PULL, 8'h00);
      apb(1'b1, IDX_FIX_B, 8'h20);
      // Back in card-power mode the driver must be forced off.
      repeat (2) @(posedge clock_i);
      chk(32'({oen[1], ien[1]}), 32'h2);
      apb(1'b1, IDX_IO, 8'h00);
   endtask
   task automatic t_short();
      int k;
      apb(1'b1, IDX_ARM, 8'h01);
      @(posedge clock_i);
      shrt <= 3'b011;
      k = 0;
      while (flg[0] !== 1'b1 && k < 20)
      begin
         @(posedge clock_i);
         k++;
      end
      chk(32'(flg), 32'h1);
      shrt <= 3'b000;
      repeat (8) @(posedge clock_i);
      apb(1'b1, IDX_SENSE, 8'h10);
      @(posedge clock_i);
      chk(32'(flg), 32'h0);
   endtask
   task automatic t_vreg();
      apb(1'b1, IDX_VAR, 8'h40);
      @(posedge clock_i);
      chk(32'(v18), 32'h1);
      apb(1'b1, IDX_VAR, 8'h50);
      repeat (12) @(posedge clock_i);
      chk(32'({oen[2], ien[2]}), 32'h3);
      rc(IDX_SENSE, 8'h05);
      apb(1'b1, IDX_VAR, 8'h70);
      @(posedge clock_i);
      chk(32'(tune), 32'h1);
      repeat (20) @(posedge clock_i);
      apb(1'b1, IDX_VAR, 8'hFF);
      rc(IDX_VAR, 8'h70);
      apb(1'b1, IDX_VAR, 8'h10);
      @(posedge clock_i);
      chk(32'({v18, tune}), 32'h0);
      apb(1'b0, 12'h900, 8'h00);
      chk({se, rd[30:0]}, 32'h80000000);
   endtask
   // Reset for five cycles, then the scenarios in turn.
   initial
   begin
      err_total = 0;
      n_tests = 0;
      rst_i = 1'b1;
      {psel, pen, pwr, pa, pwd, shrt} = '0;
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset();
      t_fixed();
      t_short();
      t_vreg();
      test_done();
   end
endmodule
`default_nettype wire
